// ### hib_defs.vh
// register offsets, field positions, reset values and timing counts for the
// hibernation power controller; included by bare name, definitions only
`ifndef HIB_DEFS_VH
`define HIB_DEFS_VH

// byte offsets on the apb bus
`define OFF_COUNTER      12'h000
`define OFF_MATCH_ZERO   12'h004
`define OFF_MATCH_ONE    12'h008
`define OFF_COUNTER_LOAD 12'h00C
`define OFF_CONTROL      12'h010
`define OFF_EVENT_MASK   12'h014
`define OFF_RAW_STATUS   12'h018
`define OFF_MASKED       12'h01C
`define OFF_EVENT_CLEAR  12'h020
`define OFF_TRIM         12'h024
`define OFF_DATA_FIRST   12'h030
`define OFF_DATA_LAST    12'h12C

// power_control field positions
`define CTL_COUNTER_EN   0
`define CTL_SLEEP_REQ    1
`define CTL_CLK_SELECT   2
`define CTL_MATCH_WAKE   3
`define CTL_PIN_WAKE     4
`define CTL_LOW_BATTERY_FLAG_EN    5
`define CTL_REF_CLK_EN   6
`define CTL_ABORT_EN     7
`define CTL_WIDTH        8

// event bit positions in mask, raw, masked and clear views
`define EV_MATCH_ZERO    0
`define EV_MATCH_ONE     1
`define EV_LOW_BATTERY   2
`define EV_WAKE_PIN      3
`define EV_WIDTH         4

// reset values
`define RST_MATCH        32'hFFFF_FFFF
`define RST_LOAD         32'hFFFF_FFFF
`define RST_TRIM         16'h7FFF
`define NOMINAL_RELOAD   16'h7FFF

// timing counts
`define CRYSTAL_DIVIDE   128
`define TRIM_PERIOD      64
`define DATA_WORDS       64

`endif

// ### hib_power_rtc.v
// hibernation power controller: regulator-off output, seconds counter
// with trimmed predivider, two match comparators, low-battery watch,
// retained words and event status, all reached over an apb slave.
// assumes the oscillator, battery comparator and wake pin are synchronous.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "hib_defs.vh"
module hib_power_rtc #(
  parameter CRYSTAL_DIVIDE = `CRYSTAL_DIVIDE,
  parameter DATA_WORDS     = `DATA_WORDS
) (
  input  wire        CLK_I,
  input  wire        SYS_RST_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  input  wire        OSC_I,
  input  wire        BATTERY_LOW_I,
  input  wire        WAKE_N_I,
  output reg         REGULATOR_OFF_N_O,
  output reg         IRQ_O
);
  // software-visible state
  reg [31:0]            rtc_match_zero;
  reg [31:0]            rtc_match_one;
  reg [31:0]            counter_load;
  reg [`CTL_WIDTH-1:0]  power_control;
  reg [`EV_WIDTH-1:0]   event_mask;
  reg [`EV_WIDTH-1:0]   raw_event_status;
  reg [15:0]            predivider_trim;
  reg [31:0]            rtc_count;

  // internal state
  reg [15:0]            predivider;
  reg [5:0]             second_index;
  reg                   hibernated;
  reg                   wake_q;

  wire counter_enable            = power_control[`CTL_COUNTER_EN];
  wire sleep_request             = power_control[`CTL_SLEEP_REQ];
  wire ref_clock_select          = power_control[`CTL_CLK_SELECT];
  wire match_wake_enable         = power_control[`CTL_MATCH_WAKE];
  wire pin_wake_enable           = power_control[`CTL_PIN_WAKE];
  wire low_battery_detect_enable = power_control[`CTL_LOW_BATTERY_FLAG_EN];
  wire ref_clock_enable          = power_control[`CTL_REF_CLK_EN];

  wire [`EV_WIDTH-1:0] masked_event_status = raw_event_status & event_mask;

  // apb decode; a write lands on the edge that completes the access
  wire       access   = PSEL_I & PENABLE_I;
  wire       wr_fire  = access & PWRITE_I & PREADY_O;
  wire       in_data  = (PADDR_I >= `OFF_DATA_FIRST) &&
                        (PADDR_I <= `OFF_DATA_LAST);
  // word index within the retained area, counted from its first byte
  wire [11:0] data_byte = PADDR_I - `OFF_DATA_FIRST;
  wire [5:0] data_idx = data_byte[7:2];
  wire       aligned  = (PADDR_I[1:0] == 2'b00);

  reg mapped;
  always @* begin
    case (PADDR_I)
      `OFF_COUNTER, `OFF_MATCH_ZERO, `OFF_MATCH_ONE, `OFF_COUNTER_LOAD,
      `OFF_CONTROL, `OFF_EVENT_MASK, `OFF_RAW_STATUS, `OFF_MASKED,
      `OFF_EVENT_CLEAR, `OFF_TRIM: mapped = 1'b1;
      default: mapped = in_data & aligned;
    endcase
  end

  wire wr_ok = wr_fire & mapped;
  wire wr_ctl   = wr_ok & (PADDR_I == `OFF_CONTROL);
  wire wr_load  = wr_ok & (PADDR_I == `OFF_COUNTER_LOAD);
  wire wr_clear = wr_ok & (PADDR_I == `OFF_EVENT_CLEAR);
  // one strobe per writable register
  wire wr_match_zero = wr_ok & (PADDR_I == `OFF_MATCH_ZERO);
  wire wr_match_one  = wr_ok & (PADDR_I == `OFF_MATCH_ONE);
  wire wr_mask       = wr_ok & (PADDR_I == `OFF_EVENT_MASK);
  wire wr_trim       = wr_ok & (PADDR_I == `OFF_TRIM);
  wire wr_store      = wr_ok & in_data;

  // reference tick, kept running through hibernation
  wire ref_tick;
  ref_clock_divider #(
    .DIVIDE   (CRYSTAL_DIVIDE)
  ) u_div (
    .clk_i    (CLK_I),
    .rst_i    (SYS_RST_I),
    .enable_i (ref_clock_enable),
    .select_i (ref_clock_select),
    .osc_i    (OSC_I),
    .tick_o   (ref_tick)
  );

  // retained words
  wire [31:0] store_q;
  retained_store #(
    .WIDTH     (32),
    .DEPTH     (DATA_WORDS),
    .ABITS     (6)
  ) u_store (
    .clk_i     (CLK_I),
    .wr_en_i   (wr_store),
    .wr_addr_i (data_idx),
    .wr_data_i (PWDATA_I),
    .rd_addr_i (data_idx),
    .rd_data_o (store_q)
  );

  // seconds timing
  wire        second_done = ref_tick & counter_enable &
                            (predivider == 16'h0000);
  wire [31:0] count_inc   = rtc_count + 32'h0000_0001;
  // one comparator per match register, checked as the counter steps
  wire [63:0] match_words = {rtc_match_one, rtc_match_zero};
  wire [1:0]  hit;
  genvar      g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_match
      assign hit[g] = second_done &
                      (count_inc == match_words[32*g +: 32]);
    end
  endgenerate
  wire        hit_zero    = hit[0];
  wire        hit_one     = hit[1];

  // battery is only looked at while powered
  wire battery_low = BATTERY_LOW_I & ~hibernated;
  wire low_battery_flag_evt  = battery_low & low_battery_detect_enable;
  wire wake_evt    = ~WAKE_N_I & wake_q;

  // hibernate entry is refused while the battery is low and both abort and low-battery detect are set
  wire sleep_write = wr_ctl & PWDATA_I[`CTL_SLEEP_REQ] & ~hibernated;
  // judged on the bits of the same write, so one write can arm the abort
  wire sleep_abort = PWDATA_I[`CTL_ABORT_EN] & PWDATA_I[`CTL_LOW_BATTERY_FLAG_EN] &
                     battery_low;
  wire pin_wake    = pin_wake_enable & ~WAKE_N_I;
  wire match_wake  = match_wake_enable & (hit_zero | hit_one);
  wire wake_now    = hibernated & (pin_wake | match_wake);

  // power state: cut on an accepted request, restored by an enabled wake
  localparam [0:0] PWR_ON  = 1'b0;
  localparam [0:0] PWR_CUT = 1'b1;
  reg next_hibernated;
  always @* begin
    next_hibernated = hibernated;
    case (hibernated)
      PWR_ON: begin
        if (sleep_write && !sleep_abort) begin
          next_hibernated = PWR_CUT;
        end
      end
      PWR_CUT: begin
        if (wake_now) begin
          next_hibernated = PWR_ON;
        end
      end
      default: begin
        next_hibernated = PWR_ON;
      end
    endcase
  end

  // predivider next value; reference ticks are dropped while stopped
  reg [15:0] next_predivider;
  reg [5:0]  next_second_index;
  always @* begin
    next_predivider   = predivider;
    next_second_index = second_index;
    if (ref_tick && counter_enable) begin
      if (predivider == 16'h0000) begin
        next_second_index = second_index + 6'h01;
        // last second of each group of 64 uses the trim value
        if (second_index == 6'h3E) begin
          next_predivider = predivider_trim;
        end else begin
          next_predivider = `NOMINAL_RELOAD;
        end
      end else begin
        next_predivider = predivider - 16'h0001;
      end
    end
  end

  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      predivider   <= `NOMINAL_RELOAD;
      second_index <= 6'h00;
      rtc_count    <= 32'h0000_0000;
    end else begin
      predivider   <= next_predivider;
      second_index <= next_second_index;
      // load wins over a coinciding increment
      if (wr_load) begin
        rtc_count <= PWDATA_I;
      end else if (second_done) begin
        rtc_count <= count_inc;
      end
    end
  end

  // register writes and power state
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rtc_match_zero    <= `RST_MATCH;
      rtc_match_one     <= `RST_MATCH;
      counter_load      <= `RST_LOAD;
      power_control     <= {`CTL_WIDTH{1'b0}};
      event_mask        <= {`EV_WIDTH{1'b0}};
      predivider_trim   <= `RST_TRIM;
      hibernated        <= 1'b0;
      REGULATOR_OFF_N_O <= 1'b1;
    end else begin
      if (wr_match_zero) begin
        rtc_match_zero <= PWDATA_I;
      end
      if (wr_match_one) begin
        rtc_match_one <= PWDATA_I;
      end
      if (wr_load) begin
        counter_load <= PWDATA_I;
      end
      if (wr_mask) begin
        event_mask <= PWDATA_I[`EV_WIDTH-1:0];
      end
      if (wr_trim) begin
        predivider_trim <= PWDATA_I[15:0];
      end
      if (wr_ctl) begin
        // request bit only sticks when the cut is really taken
        power_control <= PWDATA_I[`CTL_WIDTH-1:0];
        if (!sleep_write || sleep_abort) begin
          power_control[`CTL_SLEEP_REQ] <= 1'b0;
        end
      end
      hibernated        <= next_hibernated;
      REGULATOR_OFF_N_O <= ~next_hibernated;
      if (wake_now) begin
        // control keeps ref clock enable so software sees setup done
        power_control[`CTL_SLEEP_REQ] <= 1'b0;
      end
    end
  end

  // sticky events; a set in the clearing cycle wins
  reg [`EV_WIDTH-1:0] set_vec;
  always @* begin
    set_vec                  = {`EV_WIDTH{1'b0}};
    set_vec[`EV_MATCH_ZERO]  = hit_zero;
    set_vec[`EV_MATCH_ONE]   = hit_one;
    set_vec[`EV_LOW_BATTERY] = low_battery_flag_evt;
    set_vec[`EV_WAKE_PIN]    = wake_evt;
  end

  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      raw_event_status <= {`EV_WIDTH{1'b0}};
      wake_q           <= 1'b1;
      IRQ_O            <= 1'b0;
    end else begin
      wake_q <= WAKE_N_I;
      // raw keeps the wake cause across the power cycle
      if (wr_clear) begin
        raw_event_status <= (raw_event_status & ~PWDATA_I[`EV_WIDTH-1:0]) |
                            set_vec;
      end else begin
        raw_event_status <= raw_event_status | set_vec;
      end
      // one cycle behind the status, so a clear shows at the next edge
      IRQ_O <= |masked_event_status;
    end
  end

  // read mux; every access takes one wait state for the store's read
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (PADDR_I)
      `OFF_COUNTER:      rd_mux = rtc_count;
      `OFF_MATCH_ZERO:   rd_mux = rtc_match_zero;
      `OFF_MATCH_ONE:    rd_mux = rtc_match_one;
      `OFF_COUNTER_LOAD: rd_mux = counter_load;
      `OFF_CONTROL:      rd_mux[`CTL_WIDTH-1:0] = power_control;
      `OFF_EVENT_MASK:   rd_mux[`EV_WIDTH-1:0]  = event_mask;
      `OFF_RAW_STATUS:   rd_mux[`EV_WIDTH-1:0]  = raw_event_status;
      `OFF_MASKED:       rd_mux[`EV_WIDTH-1:0]  = masked_event_status;
      `OFF_TRIM:         rd_mux[15:0] = predivider_trim;
      default: begin
        if (in_data && aligned) begin
          rd_mux = store_q;
        end
      end
    endcase
  end

  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      if (access && !PREADY_O) begin
        PREADY_O  <= 1'b1;
        PSLVERR_O <= ~mapped;
        if (!PWRITE_I && mapped) begin
          PRDATA_O <= rd_mux;
        end else begin
          PRDATA_O <= 32'h0000_0000;
        end
      end else begin
        PREADY_O  <= 1'b0;
        PSLVERR_O <= 1'b0;
      end
    end
  end
endmodule

// ### hib_power_rtc_properties.sv
// concurrent checks on the hibernation power controller top ports
// assumes one clock domain; control and mask are shadowed from bus writes
`timescale 1ns/1ps
`include "hib_defs.vh"
module hib_power_rtc_checker (
  input logic        CLK_I,
  input logic        SYS_RST_I,
  input logic        PSEL_I,
  input logic        PENABLE_I,
  input logic        PWRITE_I,
  input logic [11:0] PADDR_I,
  input logic [31:0] PWDATA_I,
  input logic [31:0] PRDATA_O,
  input logic        PREADY_O,
  input logic        PSLVERR_O,
  input logic        OSC_I,
  input logic        BATTERY_LOW_I,
  input logic        WAKE_N_I,
  input logic        REGULATOR_OFF_N_O,
  input logic        IRQ_O
);
  logic [7:0] ctl;
  logic [3:0] msk;
  logic       done;
  logic       sleep_wr;
  assign done = PSEL_I && PENABLE_I && PREADY_O;
  assign sleep_wr = done && PWRITE_I && PADDR_I == `OFF_CONTROL
                    && PWDATA_I[`CTL_SLEEP_REQ];
  // shadow copies, so wake enables and mask need no internal probes
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ctl <= 8'h00;
      msk <= 4'h0;
    end else if (done && PWRITE_I && !PSLVERR_O) begin
      if (PADDR_I == `OFF_CONTROL)
        ctl <= PWDATA_I[7:0];
      if (PADDR_I == `OFF_EVENT_MASK)
        msk <= PWDATA_I[3:0];
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_sleep_wr;
    sleep_wr && REGULATOR_OFF_N_O;
  endsequence
  AST_SLEEP_CUT: assert property (s_sleep_wr ##0 !PWDATA_I[7]
    |=> !REGULATOR_OFF_N_O) else $error("sleep write kept power on");
  AST_ABORT_KEEP: assert property (s_sleep_wr ##0 (PWDATA_I[7]
    && PWDATA_I[5] && BATTERY_LOW_I) |=> REGULATOR_OFF_N_O [*2])
    else $error("power cut despite low battery abort");
  AST_CUT_CAUSE: assert property ($fell(REGULATOR_OFF_N_O)
    |-> $past(sleep_wr)) else $error("power cut without sleep write");
  AST_PIN_WAKE: assert property (!REGULATOR_OFF_N_O && !WAKE_N_I
    && ctl[`CTL_PIN_WAKE] |=> REGULATOR_OFF_N_O)
    else $error("wake pin did not restore power");
  AST_STAY_OFF: assert property (!REGULATOR_OFF_N_O && WAKE_N_I
    && !ctl[`CTL_MATCH_WAKE] |=> !REGULATOR_OFF_N_O)
    else $error("power restored with no wake cause");
  AST_RST_STATE: assert property ($fell(SYS_RST_I)
    |-> REGULATOR_OFF_N_O && !IRQ_O && !PREADY_O)
    else $error("outputs wrong after reset");
  AST_IRQ_OFF: assert property (msk == 4'h0 && $past(msk) == 4'h0
    |-> !IRQ_O) else $error("interrupt with all events masked");
  AST_MASKED_READ: assert property (done && !PWRITE_I
    && PADDR_I == `OFF_MASKED |-> (PRDATA_O[3:0] & ~msk) == 4'h0
    && PRDATA_O[31:4] == '0) else $error("masked view shows masked bit");
  AST_CLEAR_READ: assert property (done && !PWRITE_I
    && PADDR_I == `OFF_EVENT_CLEAR |-> PRDATA_O == 32'h0)
    else $error("clear register read not zero");
endmodule
bind hib_power_rtc hib_power_rtc_checker i_chk (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .OSC_I(OSC_I), .BATTERY_LOW_I(BATTERY_LOW_I),
  .WAKE_N_I(WAKE_N_I), .REGULATOR_OFF_N_O(REGULATOR_OFF_N_O),
  .IRQ_O(IRQ_O));

// ### ref_clock_divider.v
// reference tick generator: one-cycle pulse per 32.768 khz reference rising edge with select high, per DIVIDE rising edges with select low
// assumes the oscillator level arrives synchronous to CLK_I
`timescale 1ns/1ps
module ref_clock_divider #(
  parameter DIVIDE = 128
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire enable_i,
  input  wire select_i,
  input  wire osc_i,
  output reg  tick_o
);
  reg       osc_q;
  reg [6:0] div_count;
  wire      rise = osc_i & ~osc_q;

  // select high passes the oscillator, low divides the crystal
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_q     <= 1'b0;
      div_count <= 7'h00;
      tick_o    <= 1'b0;
    end else begin
      osc_q  <= osc_i;
      tick_o <= 1'b0;
      if (enable_i && rise) begin
        if (select_i) begin
          tick_o <= 1'b1;
        end else if (div_count == DIVIDE[6:0] - 7'h01) begin
          div_count <= 7'h00;
          tick_o    <= 1'b1;
        end else begin
          div_count <= div_count + 7'h01;
        end
      end
    end
  end
endmodule

// ### regulator_wake_model.sv
// external regulator and wake pin seen from the controller
// assumes the bench presses the pin only to end hibernation
`timescale 1ns/1ps
module regulator_wake_model (
  input  wire logic clk_i,
  input  wire logic regulator_off_n_i,
  input  wire logic press_i,
  output logic      wake_n_o,
  output logic      supply_on_o
);
  // weak pull-up: the pin idles high whenever nobody presses it
  initial wake_n_o = 1'b1;
  always @(posedge clk_i) begin
    wake_n_o <= !press_i;
  end
  // no ramp modelled, so a late power-good would go unnoticed
  assign supply_on_o = regulator_off_n_i;
endmodule

// ### retained_store.v
// retained word store; write port and registered read port on one clock
// assumes its supply survives hibernation, so it has no reset
`timescale 1ns/1ps
module retained_store #(
  parameter WIDTH = 32,
  parameter DEPTH = 64,
  parameter ABITS = 6
) (
  input  wire             clk_i,
  input  wire             wr_en_i,
  input  wire [ABITS-1:0] wr_addr_i,
  input  wire [WIDTH-1:0] wr_data_i,
  input  wire [ABITS-1:0] rd_addr_i,
  output reg  [WIDTH-1:0] rd_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ### tb_hibernation_power_rtc.sv
// self-checking bench for the hibernation power controller over apb
// assumes a synchronous oscillator level toggled once per clock
`timescale 1ns/1ps
module tb_hibernation_power_rtc;
  logic        clk, rst, psel, penable, pwrite, osc, batt, press, osc_run;
  logic        pready, pslverr, irq, reg_n, wake_n, supply, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int          n_errors = 0, n_checks = 0, cyc = 0, n;
  logic [11:0] ra [10] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
                           12'h014, 12'h018, 12'h01C, 12'h020, 12'h024};
  logic [31:0] re [10] = '{32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
                           32'hFFFF_FFFF, 32'h0, 32'h0, 32'h0, 32'h0,
                           32'h0, 32'h0000_7FFF};
  hib_power_rtc #(.CRYSTAL_DIVIDE(4), .DATA_WORDS(64)) i_dut (
    .CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .OSC_I(osc), .BATTERY_LOW_I(batt), .WAKE_N_I(wake_n),
    .REGULATOR_OFF_N_O(reg_n), .IRQ_O(irq));
  regulator_wake_model i_reg (.clk_i(clk), .regulator_off_n_i(reg_n),
    .press_i(press), .wake_n_o(wake_n), .supply_on_o(supply));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (osc_run)
      osc <= ~osc;
    cyc++;
    if (cyc == 95000) begin
      n_errors++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the bench timeout ends a wait that never gets its answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [11:0] a,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  initial begin
    clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; osc = 0; batt = 0; press = 0; osc_run = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) rc("reset", ra[i], re[i]);
    bus(1'b1, 12'h000, 32'hFFFF_0000);
    rc("ro", 12'h000, 32'h0);
    bus(1'b1, 12'h030, 32'hA5A5_0001);
    bus(1'b1, 12'h12C, 32'h5A5A_003F);
    rc("word0", 12'h030, 32'hA5A5_0001);
    rc("word63", 12'h12C, 32'h5A5A_003F);
    bus(1'b1, 12'h024, 32'h0000_8000);
    rc("trim", 12'h024, 32'h0000_8000);
    bus(1'b0, 12'h130, 32'h0);
    chk("slverr", {31'h0, se}, 32'h1);
    // crystal start first: divided path, then the settling wait
    bus(1'b1, 12'h010, 32'h0000_0040);
    repeat (50) @(posedge clk);
    rc("xtal", 12'h010, 32'h0000_0040);
    // oscillator path needs no settling wait before further access
    bus(1'b1, 12'h010, 32'h0000_0044);
    osc_run <= 1'b1;
    repeat (200) @(posedge clk);
    rc("hold", 12'h000, 32'h0);
    bus(1'b1, 12'h00C, 32'h0000_0010);
    repeat (2) @(posedge clk);
    rc("load", 12'h000, 32'h0000_0010);
    rc("ldreg", 12'h00C, 32'h0000_0010);
    bus(1'b1, 12'h004, 32'h0000_0011);
    bus(1'b1, 12'h008, 32'h0000_0011);
    bus(1'b1, 12'h014, 32'h0000_0003);
    bus(1'b1, 12'h010, 32'h0000_0045);
    repeat (60000) @(posedge clk);
    rc("early", 12'h000, 32'h0000_0010);
    n = 0;
    while (irq !== 1'b1 && n < 8000) begin
      @(posedge clk);
      n++;
    end
    osc_run <= 1'b0;
    rc("second", 12'h000, 32'h0000_0011);
    rc("raw", 12'h018, 32'h0000_0003);
    rc("masked", 12'h01C, 32'h0000_0003);
    bus(1'b1, 12'h014, 32'h0000_0001);
    rc("masked", 12'h01C, 32'h0000_0001);
    rc("raw", 12'h018, 32'h0000_0003);
    bus(1'b1, 12'h020, 32'h0000_0003);
    rc("raw", 12'h018, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    batt <= 1'b1;
    bus(1'b1, 12'h010, 32'h0000_0064);
    rc("low_battery_flag", 12'h018, 32'h0000_0004);
    bus(1'b1, 12'h010, 32'h0000_00E6);
    repeat (2) @(posedge clk);
    chk("abort", {31'h0, supply}, 32'h1);
    rc("ctl", 12'h010, 32'h0000_00E4);
    batt <= 1'b0;
    bus(1'b1, 12'h020, 32'h0000_0004);
    // pin wake armed in the same write that requests sleep
    bus(1'b1, 12'h010, 32'h0000_0076);
    repeat (2) @(posedge clk);
    chk("cut", {31'h0, supply}, 32'h0);
    batt <= 1'b1;
    repeat (4) @(posedge clk);
    rc("nobat", 12'h018, 32'h0);
    batt <= 1'b0;
    press <= 1'b1;
    n = 0;
    while (supply !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    chk("wake", {31'h0, supply}, 32'h1);
    press <= 1'b0;
    rc("cause", 12'h018, 32'h0000_0008);
    rc("ctl", 12'h010, 32'h0000_0074);
    wrap_up;
  end
endmodule
